//--- rtl/general_control_pkg.sv
// Constants and types for the upper general control register
// Overview of operation
// - 32-bit read/write register at D0h, resets zero
// - Bit 25 low, no GPIO: pair five is PCI arbitration
// - Bit 25 high, no GPIO: PC/PCI channel B
// - GPIO use-select high: pair five is GPIO
// - Bit 24 hides bridge: AD22 held low in bridge config cycles
// - Bit 21 makes numeric error a C2 break
// - Bits 19:18 are plain scratch storage
// - Bit 13 low: no interrupt 13, no ignore
// - Numeric error latches interrupt 13 until F0h write
// - Numeric error also drives ignore output active
// - Bit 12 latches keyboard edge until 60h read
// - Bit 11 latches mouse edge until 60h read
package general_control_pkg;
   localparam logic [7:0]  GENERAL_CONTROL_OFFSET = 8'hD0;
   localparam logic [31:0] GENERAL_CONTROL_RESET  = 32'h0000_0000;
   localparam logic [31:0] GENERAL_CONTROL_MASK   = 32'h032C_3800;
   localparam int          PAIR_FIVE_PROTOCOL_BIT = 25;
   localparam int          HIDE_BRIDGE_BIT        = 24;
   localparam int          NUMERIC_BREAK_BIT      = 21;
   localparam int          SCRATCH_HI_BIT         = 19;
   localparam int          SCRATCH_LO_BIT         = 18;
   localparam int          COPROC_ERROR_BIT       = 13;
   localparam int          KEYBOARD_LATCH_BIT     = 12;
   localparam int          MOUSE_LATCH_BIT        = 11;
   localparam int          PIN_COUNT              = 4;
   localparam int          PIN_REQ5               = 0;
   localparam int          PIN_NUMERIC_ERR        = 1;
   localparam int          PIN_IRQ1               = 2;
   localparam int          PIN_IRQ12              = 3;
   localparam logic [3:0]  PIN_IDLE               = 4'h3;
   typedef enum logic [1:0] {PAIR_PCI, PAIR_PCPCI, PAIR_GPIO} pair_mode_t;
endpackage : general_control_pkg

//--- rtl/general_control.sv
// Upper general control register and the logic it steers
`timescale 1ns/10ps
`default_nettype none
module general_control
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cfg_wr_i,
   input  wire logic        cfg_rd_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_be_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic      [31:0] cfg_rdata_o,
   output logic             cfg_ack_o,
   input  wire logic        gpio_use_sel_i,
   input  wire logic        req5_n_i,
   input  wire logic        arb_gnt5_i,
   input  wire logic        dmab_gnt_i,
   input  wire logic        gpo5_i,
   output logic             gnt5_n_o,
   output logic             arb_req5_o,
   output logic             dmab_req_o,
   output logic             gpi5_o,
   input  wire logic        bridge_cfg_cycle_i,
   input  wire logic        ad22_i,
   output logic             ad22_o,
   input  wire logic        c2_state_i,
   input  wire logic        numeric_error_in_n_i,
   output logic             break_event_o,
   input  wire logic        port_f0_wr_i,
   output logic             irq13_o,
   output logic             ignore_numeric_error_out_n_o,
   input  wire logic        irq1_i,
   input  wire logic        irq12_i,
   input  wire logic        port_60_rd_i,
   output logic             irq1_o,
   output logic             irq12_o
);

   // Register storage and access
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic        hit;
   logic [31:0] be_mask;

   assign hit = cfg_addr_i[7:2] == general_control_pkg::GENERAL_CONTROL_OFFSET[7:2];

   always_comb
   begin
      be_mask   = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
      ctrl_nxt  = ctrl_r;
      rdata_nxt = 32'h0000_0000;
      ack_nxt   = cfg_wr_i | cfg_rd_i;
      if (cfg_wr_i && hit)
      begin
         ctrl_nxt = ((ctrl_r & ~be_mask) | (cfg_wdata_i & be_mask))
                    & general_control_pkg::GENERAL_CONTROL_MASK;
      end
      if (cfg_rd_i && hit)
      begin
         rdata_nxt = ctrl_r & general_control_pkg::GENERAL_CONTROL_MASK;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r  <= general_control_pkg::GENERAL_CONTROL_RESET;
         rdata_r <= 32'h0000_0000;
         ack_r   <= 1'b0;
      end
      else
      begin
         ctrl_r  <= ctrl_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   assign cfg_rdata_o = rdata_r;
   assign cfg_ack_o   = ack_r;

   // Pin synchronisers; a change counts once stages two and three agree
   logic [general_control_pkg::PIN_COUNT-1:0] pin_raw;
   logic [general_control_pkg::PIN_COUNT-1:0] pin_f;
   logic [general_control_pkg::PIN_COUNT-1:0] pin_prev;

   assign pin_raw = {irq12_i, irq1_i, numeric_error_in_n_i, req5_n_i};

   genvar g;
   generate
      for (g = 0; g < general_control_pkg::PIN_COUNT; g++)
      begin : sync_g
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic f_r;
         logic p_r;
         logic f_nxt;
         always_comb
         begin
            f_nxt = (s2_r == s3_r) ? s3_r : f_r;
         end
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               // Idle level, so no false request or edge follows reset
               s1_r <= general_control_pkg::PIN_IDLE[g];
               s2_r <= general_control_pkg::PIN_IDLE[g];
               s3_r <= general_control_pkg::PIN_IDLE[g];
               f_r  <= general_control_pkg::PIN_IDLE[g];
               p_r  <= general_control_pkg::PIN_IDLE[g];
            end
            else
            begin
               s1_r <= pin_raw[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               f_r  <= f_nxt;
               p_r  <= f_r;
            end
         end
         assign pin_f[g]    = f_r;
         assign pin_prev[g] = p_r;
      end
   endgenerate

   // Pair five routing
   general_control_pkg::pair_mode_t mode;
   logic gnt5_n_r;
   logic gnt5_n_nxt;
   logic arb_req_r;
   logic arb_req_nxt;
   logic dmab_req_r;
   logic dmab_req_nxt;
   logic gpi_r;
   logic gpi_nxt;
   logic req_act;

   assign req_act = ~pin_f[general_control_pkg::PIN_REQ5];

   always_comb
   begin
      if (gpio_use_sel_i)
         mode = general_control_pkg::PAIR_GPIO;
      else if (ctrl_r[general_control_pkg::PAIR_FIVE_PROTOCOL_BIT])
         mode = general_control_pkg::PAIR_PCPCI;
      else
         mode = general_control_pkg::PAIR_PCI;
      gnt5_n_nxt   = 1'b1;
      arb_req_nxt  = 1'b0;
      dmab_req_nxt = 1'b0;
      gpi_nxt      = 1'b0;
      unique case (mode)
         general_control_pkg::PAIR_PCI:
         begin
            arb_req_nxt = req_act;
            gnt5_n_nxt  = ~arb_gnt5_i;
         end
         general_control_pkg::PAIR_PCPCI:
         begin
            dmab_req_nxt = req_act;
            gnt5_n_nxt   = ~dmab_gnt_i;
         end
         general_control_pkg::PAIR_GPIO:
         begin
            gpi_nxt    = pin_f[general_control_pkg::PIN_REQ5];
            gnt5_n_nxt = gpo5_i;
         end
      endcase
   end

   // Bridge hiding, break event and coprocessor error
   logic ad22_r;
   logic ad22_nxt;
   logic brk_r;
   logic brk_nxt;
   logic irq13_r;
   logic irq13_nxt;
   logic ignore_n_r;
   logic ignore_n_nxt;
   logic num_err_act;
   logic copr_en;

   assign num_err_act = ~pin_f[general_control_pkg::PIN_NUMERIC_ERR];
   assign copr_en  = ctrl_r[general_control_pkg::COPROC_ERROR_BIT];

   always_comb
   begin
      ad22_nxt = ad22_i & ~(ctrl_r[general_control_pkg::HIDE_BRIDGE_BIT] & bridge_cfg_cycle_i);
      brk_nxt  = ctrl_r[general_control_pkg::NUMERIC_BREAK_BIT] & c2_state_i & num_err_act;
      if (!copr_en)
         irq13_nxt = 1'b0;
      else
         irq13_nxt = (irq13_r & ~port_f0_wr_i) | num_err_act;
      ignore_n_nxt = ~(copr_en & num_err_act);
   end

   // Keyboard and mouse interrupt latches
   logic [1:0] irq_lvl;
   logic [1:0] irq_rise;
   logic [1:0] irq_en;
   logic [1:0] latch_r;
   logic [1:0] latch_nxt;
   logic [1:0] irq_out_r;
   logic [1:0] irq_out_nxt;

   assign irq_lvl  = {pin_f[general_control_pkg::PIN_IRQ12], pin_f[general_control_pkg::PIN_IRQ1]};
   assign irq_rise = irq_lvl & ~{pin_prev[general_control_pkg::PIN_IRQ12], pin_prev[general_control_pkg::PIN_IRQ1]};
   assign irq_en   = {ctrl_r[general_control_pkg::MOUSE_LATCH_BIT], ctrl_r[general_control_pkg::KEYBOARD_LATCH_BIT]};

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (irq_en[i])
         begin
            latch_nxt[i]   = (latch_r[i] & ~port_60_rd_i) | irq_rise[i];
            irq_out_nxt[i] = latch_nxt[i];
         end
         else
         begin
            latch_nxt[i]   = 1'b0;
            irq_out_nxt[i] = irq_lvl[i];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gnt5_n_r   <= 1'b1;
         arb_req_r  <= 1'b0;
         dmab_req_r <= 1'b0;
         gpi_r      <= 1'b0;
         ad22_r     <= 1'b0;
         brk_r      <= 1'b0;
         irq13_r    <= 1'b0;
         ignore_n_r <= 1'b1;
         latch_r    <= 2'h0;
         irq_out_r  <= 2'h0;
      end
      else
      begin
         gnt5_n_r   <= gnt5_n_nxt;
         arb_req_r  <= arb_req_nxt;
         dmab_req_r <= dmab_req_nxt;
         gpi_r      <= gpi_nxt;
         ad22_r     <= ad22_nxt;
         brk_r      <= brk_nxt;
         irq13_r    <= irq13_nxt;
         ignore_n_r <= ignore_n_nxt;
         latch_r    <= latch_nxt;
         irq_out_r  <= irq_out_nxt;
      end
   end

   assign gnt5_n_o                     = gnt5_n_r;
   assign arb_req5_o                   = arb_req_r;
   assign dmab_req_o                   = dmab_req_r;
   assign gpi5_o                       = gpi_r;
   assign ad22_o                       = ad22_r;
   assign break_event_o                = brk_r;
   assign irq13_o                      = irq13_r;
   assign ignore_numeric_error_out_n_o = ignore_n_r;
   assign irq1_o                       = irq_out_r[0];
   assign irq12_o                      = irq_out_r[1];

   // Checks
   full_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_wr_i && hit && cfg_be_i == 4'hF |=> ctrl_r == ($past(cfg_wdata_i) & general_control_pkg::GENERAL_CONTROL_MASK))
      else $error("register write not stored");
   reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_rd_i |=> (cfg_rdata_o & ~general_control_pkg::GENERAL_CONTROL_MASK) == 32'h0000_0000 && cfg_ack_o)
      else $error("reserved bits read nonzero");
   pci_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !gpio_use_sel_i && !ctrl_r[25] |=> gnt5_n_o == !$past(arb_gnt5_i) && !dmab_req_o)
      else $error("pci pair routing wrong");
   pcpci_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !gpio_use_sel_i && ctrl_r[25] |=> gnt5_n_o == !$past(dmab_gnt_i) && !arb_req5_o)
      else $error("pc pci routing wrong");
   gpio_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
      gpio_use_sel_i |=> gnt5_n_o == $past(gpo5_i) && !arb_req5_o && !dmab_req_o)
      else $error("gpio routing wrong");
   hide_bridge_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_r[24] && bridge_cfg_cycle_i |=> !ad22_o)
      else $error("ad22 asserted while hidden");
   break_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 break_event_o == $past(ctrl_r[21] && c2_state_i && num_err_act))
      else $error("break event wrong");
   scratch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cfg_wr_i && hit) |=> $stable(ctrl_r[19:18]))
      else $error("scratch bits changed");
   copr_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !copr_en |=> !irq13_o && ignore_numeric_error_out_n_o)
      else $error("coprocessor error while disabled");
   irq13_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq13_o && copr_en && !port_f0_wr_i |=> irq13_o)
      else $error("interrupt 13 dropped early");
   ignore_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      copr_en && num_err_act |=> !ignore_numeric_error_out_n_o && irq13_o)
      else $error("ignore output not driven");
   kbd_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_en[0] && irq_rise[0] |=> irq1_o [*2] ##0 1'b1 or port_60_rd_i || !irq_en[0])
      else $error("keyboard edge not latched");
   mouse_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !irq_en[1] |=> irq12_o == $past(irq_lvl[1]))
      else $error("mouse bypass wrong");
endmodule : general_control
`default_nettype wire

//--- verification/far_side_model.sv
// Far side model: PCI arbiter and PC/PCI channel B grant source
`timescale 1ns/10ps
`default_nettype none
module far_side_model
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] delay_i,
   input  wire logic       arb_req_i,
   input  wire logic       dma_req_i,
   output logic            arb_gnt_o,
   output logic            dma_gnt_o
);
   int cnt = 0;
   // Grants after a chosen wait, withdrawn as soon as the request drops
   always @(posedge clk_i)
   begin
      cnt = (rst_i || !(arb_req_i || dma_req_i)) ? 0 : cnt + 1;
      arb_gnt_o <= #2 !rst_i && arb_req_i && cnt > delay_i;
      dma_gnt_o <= #2 !rst_i && dma_req_i && cnt > delay_i;
   end
endmodule : far_side_model
`default_nettype wire

//--- verification/general_control_tb_top.sv
// Self-checking bench for the upper general control register
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); end end
module general_control_tb_top;
   logic        clk_i = 0, rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, gpio_use_sel_i = 0, req5_n_i = 1;
   logic        arb_gnt5_i, dmab_gnt_i, gpo5_i = 0, bridge_cfg_cycle_i = 0, ad22_i = 0, c2_state_i = 0;
   logic        numeric_error_in_n_i = 1, port_f0_wr_i = 0, irq1_i = 0, irq12_i = 0, port_60_rd_i = 0;
   logic [7:0]  cfg_addr_i = 0;
   logic [3:0]  cfg_be_i = 0;
   logic [31:0] cfg_wdata_i = 0, cfg_rdata_o;
   logic        cfg_ack_o, gnt5_n_o, arb_req5_o, dmab_req_o, gpi5_o, ad22_o, break_event_o, irq13_o;
   logic        ignore_numeric_error_out_n_o, irq1_o, irq12_o;
   logic [1:0]  gnt_delay = 0;
   int          error_cnt = 0, num_checks = 0, ctrl_m = 0;
   int          modes[$] = '{0, 1, 2, 3};
   wire  [9:0]  outs = {gnt5_n_o, arb_req5_o, dmab_req_o, gpi5_o, ad22_o, break_event_o, irq13_o,
                        ignore_numeric_error_out_n_o, irq1_o, irq12_o};

   general_control uut
   (
      .clk_i                        (clk_i),
      .rst_i                        (rst_i),
      .cfg_wr_i                     (cfg_wr_i),
      .cfg_rd_i                     (cfg_rd_i),
      .cfg_addr_i                   (cfg_addr_i),
      .cfg_be_i                     (cfg_be_i),
      .cfg_wdata_i                  (cfg_wdata_i),
      .cfg_rdata_o                  (cfg_rdata_o),
      .cfg_ack_o                    (cfg_ack_o),
      .gpio_use_sel_i               (gpio_use_sel_i),
      .req5_n_i                     (req5_n_i),
      .arb_gnt5_i                   (arb_gnt5_i),
      .dmab_gnt_i                   (dmab_gnt_i),
      .gpo5_i                       (gpo5_i),
      .gnt5_n_o                     (gnt5_n_o),
      .arb_req5_o                   (arb_req5_o),
      .dmab_req_o                   (dmab_req_o),
      .gpi5_o                       (gpi5_o),
      .bridge_cfg_cycle_i           (bridge_cfg_cycle_i),
      .ad22_i                       (ad22_i),
      .ad22_o                       (ad22_o),
      .c2_state_i                   (c2_state_i),
      .numeric_error_in_n_i         (numeric_error_in_n_i),
      .break_event_o                (break_event_o),
      .port_f0_wr_i                 (port_f0_wr_i),
      .irq13_o                      (irq13_o),
      .ignore_numeric_error_out_n_o (ignore_numeric_error_out_n_o),
      .irq1_i                       (irq1_i),
      .irq12_i                      (irq12_i),
      .port_60_rd_i                 (port_60_rd_i),
      .irq1_o                       (irq1_o),
      .irq12_o                      (irq12_o)
   );
   far_side_model partner (.clk_i(clk_i), .rst_i(rst_i), .delay_i(gnt_delay), .arb_req_i(arb_req5_o),
                           .dma_req_i(dmab_req_o), .arb_gnt_o(arb_gnt5_i), .dma_gnt_o(dmab_gnt_i));
   always #20 clk_i = ~clk_i;

   task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
      @(posedge clk_i);
      #2 {cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, a, b, w};
      @(posedge clk_i);
      #2 cfg_wr_i = 1'b0;
      `CHK(cfg_ack_o, 1'b1)
      if (a[7:2] == 6'h34)
         for (int k = 0; k < 4; k++)
            if (b[k]) ctrl_m[8*k+:8] = w[8*k+:8];
      ctrl_m &= general_control_pkg::GENERAL_CONTROL_MASK;
   endtask : cfg_write

   task automatic cfg_read(input logic [7:0] a);
      @(posedge clk_i);
      #2 {cfg_rd_i, cfg_addr_i} = {1'b1, a};
      @(posedge clk_i);
      #2 cfg_rd_i = 1'b0;
      `CHK(cfg_ack_o, 1'b1)
      `CHK(cfg_rdata_o, (a[7:2] == 6'h34) ? 32'(ctrl_m) : 32'h0000_0000)
   endtask : cfg_read

   task automatic expect_out(input logic [9:0] m, input logic [9:0] e);
      for (int n = 0; n < 20; n++)
      begin
         @(posedge clk_i);
         #2;
         if ((outs & m) === e) break;
      end
      `CHK(outs & m, e)
   endtask : expect_out

   task automatic pulse(ref logic s);
      @(posedge clk_i);
      #2 s = 1'b1;
      @(posedge clk_i);
      #2 s = 1'b0;
   endtask : pulse

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial
   begin
      #(40 * 5000);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'h331345a4));
      repeat (20) @(posedge clk_i);
      #2 `CHK(outs, 10'h204)
      rst_i = 1'b0;
      cfg_read(8'hD0);
      for (int i = 0; i < 12; i++)
      begin
         cfg_write((i % 4 == 3) ? 8'hD4 : 8'hD0 + 8'($urandom % 4), 4'($urandom), 32'($urandom));
         cfg_read((i % 5 == 4) ? 8'hC0 : 8'hD0);
      end
      $display("test register done");
      foreach (modes[j])
         for (int r = 0; r < 2; r++)
         begin
            gnt_delay = 2'($urandom);
            cfg_write(8'hD0, 4'hF, 32'(modes[j][0]) << 25);
            {gpio_use_sel_i, req5_n_i, gpo5_i} = {modes[j][1], r[0], 1'($urandom)};
            if (modes[j][1]) expect_out(10'h3C0, {gpo5_i, 2'b00, req5_n_i, 6'h00});
            else if (modes[j][0]) expect_out(10'h380, {req5_n_i, 1'b0, !req5_n_i, 7'h00});
            else expect_out(10'h380, {req5_n_i, !req5_n_i, 1'b0, 7'h00});
         end
      $display("test pair five done");
      {bridge_cfg_cycle_i, ad22_i, c2_state_i, numeric_error_in_n_i, gpio_use_sel_i} = 5'b11100;
      for (int v = 0; v < 2; v++)
      begin
         cfg_write(8'hD0, 4'hF, (v << 24) | (v << 21) | 32'h000C_0000);
         expect_out(10'h03C, {4'h0, !v[0], v[0], 4'b0100});
      end
      cfg_read(8'hD0);
      $display("test bridge and break done");
      cfg_write(8'hD0, 4'hF, 32'h0000_3800);
      expect_out(10'h00C, 10'h008);
      numeric_error_in_n_i = 1'b1;
      repeat (8) @(posedge clk_i);
      expect_out(10'h00C, 10'h00C);
      pulse(port_f0_wr_i);
      expect_out(10'h00C, 10'h004);
      {irq1_i, irq12_i} = 2'b11;
      repeat (8) @(posedge clk_i);
      #2 {irq1_i, irq12_i} = 2'b00;
      repeat (8) @(posedge clk_i);
      expect_out(10'h003, 10'h003);
      pulse(port_60_rd_i);
      expect_out(10'h003, 10'h000);
      cfg_write(8'hD0, 4'hF, 32'h0000_0000);
      irq1_i = 1'b1;
      expect_out(10'h00F, 10'h006);
      {irq1_i, irq12_i} = 2'b01;
      expect_out(10'h003, 10'h001);
      $display("test interrupts done");
      finish_test();
   end
endmodule : general_control_tb_top
`default_nettype wire
